// *** logic/tap_debug_access_port.v ***
// test access port controller, scan chains, comm register and break point unit
`timescale 1ns/10ps
`include "tap_debug_defines.vh"

module tap_debug_access_port #(
    parameter BSC_LEN = 8,
    // arbitrary identification value, low bit must be one
    parameter [31:0] ID_CODE = 32'h0A5A_5001
) (
    input wire mclk,
    input wire arst_n,
    input wire test_clock_pin,
    input wire test_mode_select_pin,
    input wire test_data_in_pin,
    output reg test_data_out_pin,
    output reg test_data_out_oe,
    output reg tap_pullup_en,
    input wire tap_port_enable_fuse,
    input wire debug_enable_fuse,
    input wire lock_bit_one,
    input wire lock_bit_two,
    input wire [BSC_LEN-1:0] bsc_pin_in,
    output reg [BSC_LEN-1:0] bsc_pin_out,
    output reg bsc_drive,
    output reg cpu_reset_req,
    output reg [15:0] inject_word,
    output reg inject_strobe,
    input wire [15:0] cpu_pc,
    input wire cpu_pc_valid,
    input wire cpu_flow_change,
    input wire [15:0] cpu_data_addr,
    input wire cpu_data_valid,
    output reg break_req,
    output reg debug_active,
    input wire [1:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// no test reset pin exists; only arst_n, the port enable fuse and mode select reset the tap
reg tck_m_r, tck_s_r, tck_d_r;
reg tms_m_r, tms_s_r;
reg tdi_m_r, tdi_s_r;
reg [3:0] fz_m_r, fz_s_r;
reg [BSC_LEN-1:0] bpin_m_r, bpin_s_r;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        tck_m_r <= 1'b0;
        tck_s_r <= 1'b0;
        tck_d_r <= 1'b0;
        tms_m_r <= 1'b1;
        tms_s_r <= 1'b1;
        tdi_m_r <= 1'b1;
        tdi_s_r <= 1'b1;
        fz_m_r <= 4'h0;
        fz_s_r <= 4'h0;
        bpin_m_r <= {BSC_LEN{1'b0}};
        bpin_s_r <= {BSC_LEN{1'b0}};
    end else begin
        tck_m_r <= test_clock_pin;
        tck_s_r <= tck_m_r;
        tck_d_r <= tck_s_r;
        tms_m_r <= test_mode_select_pin;
        tms_s_r <= tms_m_r;
        tdi_m_r <= test_data_in_pin;
        tdi_s_r <= tdi_m_r;
        // fuse levels are static but still come from outside the clock
        fz_m_r <= {lock_bit_two, lock_bit_one, debug_enable_fuse, tap_port_enable_fuse};
        fz_s_r <= fz_m_r;
        bpin_m_r <= bsc_pin_in;
        bpin_s_r <= bpin_m_r;
    end
end

wire rise = tck_s_r & ~tck_d_r;
wire fall = ~tck_s_r & tck_d_r;
wire tap_on = fz_s_r[0];
wire debug_ok = fz_s_r[1] & ~fz_s_r[2] & ~fz_s_r[3];

// ----------------------------------------------------------------
// tap controller
// ----------------------------------------------------------------
reg [3:0] st_r;
reg [3:0] st_nxt;

always @* begin
    case (st_r)
        `TS_TLR: st_nxt = tms_s_r ? `TS_TLR : `TS_RTI;
        `TS_RTI: st_nxt = tms_s_r ? `TS_SEL_DR : `TS_RTI;
        `TS_SEL_DR: st_nxt = tms_s_r ? `TS_SEL_IR : `TS_CAP_DR;
        `TS_CAP_DR: st_nxt = tms_s_r ? `TS_EX1_DR : `TS_SH_DR;
        `TS_SH_DR: st_nxt = tms_s_r ? `TS_EX1_DR : `TS_SH_DR;
        `TS_EX1_DR: st_nxt = tms_s_r ? `TS_UPD_DR : `TS_PAU_DR;
        `TS_PAU_DR: st_nxt = tms_s_r ? `TS_EX2_DR : `TS_PAU_DR;
        `TS_EX2_DR: st_nxt = tms_s_r ? `TS_UPD_DR : `TS_SH_DR;
        `TS_UPD_DR: st_nxt = tms_s_r ? `TS_SEL_DR : `TS_RTI;
        `TS_SEL_IR: st_nxt = tms_s_r ? `TS_TLR : `TS_CAP_IR;
        `TS_CAP_IR: st_nxt = tms_s_r ? `TS_EX1_IR : `TS_SH_IR;
        `TS_SH_IR: st_nxt = tms_s_r ? `TS_EX1_IR : `TS_SH_IR;
        `TS_EX1_IR: st_nxt = tms_s_r ? `TS_UPD_IR : `TS_PAU_IR;
        `TS_PAU_IR: st_nxt = tms_s_r ? `TS_EX2_IR : `TS_PAU_IR;
        `TS_EX2_IR: st_nxt = tms_s_r ? `TS_UPD_IR : `TS_SH_IR;
        `TS_UPD_IR: st_nxt = tms_s_r ? `TS_SEL_DR : `TS_RTI;
        default: st_nxt = `TS_TLR;
    endcase
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
        st_r <= `TS_TLR;
    else if (!tap_on)
        st_r <= `TS_TLR;
    else if (rise)
        st_r <= st_nxt;
end

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
reg [`IR_W-1:0] ir_sh_r, ir_r;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        ir_sh_r <= `IR_CAPTURE;
        ir_r <= `OP_IDCODE;
    end else if (!tap_on) begin
        ir_r <= `OP_IDCODE;
    end else if (rise) begin
        // exit and pause states fall to the default and hold everything
        case (st_r)
            `TS_TLR: ir_r <= `OP_IDCODE;
            `TS_CAP_IR: ir_sh_r <= `IR_CAPTURE;
            `TS_SH_IR: ir_sh_r <= {tdi_s_r, ir_sh_r[`IR_W-1:1]};
            `TS_UPD_IR: ir_r <= ir_sh_r;
            default: ir_r <= ir_r;
        endcase
    end
end

// private chains fall back to bypass while debug is locked out
reg [`IR_W-1:0] ir_eff;
always @* begin
    ir_eff = ir_r;
    case (ir_r)
        `OP_CPU_SCAN, `OP_BP_SCAN, `OP_COMM: begin
            if (!debug_active)
                ir_eff = `OP_BYPASS;
        end
        `OP_EXTEST, `OP_IDCODE, `OP_SAMPLE, `OP_RESET: ir_eff = ir_r;
        default: ir_eff = `OP_BYPASS;
    endcase
end

// ----------------------------------------------------------------
// data registers
// ----------------------------------------------------------------
reg [`ID_W-1:0] id_sh_r;
reg byp_r;
reg [BSC_LEN-1:0] bsc_sh_r;
reg rst_sh_r;
reg [`CPU_SCAN_W-1:0] cpu_sh_r;
reg [`BP_W-1:0] bp_sh_r, bp_cfg_r;
reg [`COMM_W-1:0] comm_sh_r;
reg [7:0] comm_r;
reg dirty_r;
reg inj_pend_r;

wire cap_dr = rise & (st_r == `TS_CAP_DR);
wire sh_dr = rise & (st_r == `TS_SH_DR);
wire upd_dr = rise & (st_r == `TS_UPD_DR);
wire run_idle = rise & (st_r == `TS_RTI);

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        id_sh_r <= {`ID_W{1'b0}};
        byp_r <= 1'b0;
        bsc_sh_r <= {BSC_LEN{1'b0}};
        rst_sh_r <= 1'b0;
        cpu_sh_r <= {`CPU_SCAN_W{1'b0}};
        bp_sh_r <= {`BP_W{1'b0}};
        comm_sh_r <= {`COMM_W{1'b0}};
    end else if (cap_dr) begin
        case (ir_eff)
            `OP_IDCODE: id_sh_r <= ID_CODE;
            `OP_EXTEST, `OP_SAMPLE: bsc_sh_r <= bpin_s_r;
            `OP_RESET: rst_sh_r <= cpu_reset_req;
            `OP_CPU_SCAN: cpu_sh_r <= inject_word;
            `OP_BP_SCAN: bp_sh_r <= bp_cfg_r;
            `OP_COMM: comm_sh_r <= comm_r;
            default: byp_r <= 1'b0;
        endcase
    end else if (sh_dr) begin
        case (ir_eff)
            `OP_IDCODE: id_sh_r <= {tdi_s_r, id_sh_r[`ID_W-1:1]};
            `OP_EXTEST, `OP_SAMPLE: bsc_sh_r <= {tdi_s_r, bsc_sh_r[BSC_LEN-1:1]};
            `OP_RESET: rst_sh_r <= tdi_s_r;
            `OP_CPU_SCAN: cpu_sh_r <= {tdi_s_r, cpu_sh_r[`CPU_SCAN_W-1:1]};
            `OP_BP_SCAN: bp_sh_r <= {tdi_s_r, bp_sh_r[`BP_W-1:1]};
            `OP_COMM: comm_sh_r <= {tdi_s_r, comm_sh_r[`COMM_W-1:1]};
            default: byp_r <= tdi_s_r;
        endcase
    end
end

reg dr_bit;
always @* begin
    case (ir_eff)
        `OP_IDCODE: dr_bit = id_sh_r[0];
        `OP_EXTEST, `OP_SAMPLE: dr_bit = bsc_sh_r[0];
        `OP_RESET: dr_bit = rst_sh_r;
        `OP_CPU_SCAN: dr_bit = cpu_sh_r[0];
        `OP_BP_SCAN: dr_bit = bp_sh_r[0];
        `OP_COMM: dr_bit = comm_sh_r[0];
        default: dr_bit = byp_r;
    endcase
end

// latched parallel outputs and the run-test/idle action
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        bsc_pin_out <= {BSC_LEN{1'b0}};
        cpu_reset_req <= 1'b0;
        inject_word <= 16'h0000;
        inject_strobe <= 1'b0;
        inj_pend_r <= 1'b0;
        bp_cfg_r <= {`BP_W{1'b0}};
        bsc_drive <= 1'b0;
        debug_active <= 1'b0;
        tap_pullup_en <= 1'b0;
    end else begin
        inject_strobe <= 1'b0;
        bsc_drive <= tap_on & (ir_r == `OP_EXTEST);
        debug_active <= tap_on & debug_ok;
        tap_pullup_en <= tap_on;
        if (!debug_ok)
            inj_pend_r <= 1'b0;
        if (upd_dr) begin
            case (ir_eff)
                `OP_EXTEST, `OP_SAMPLE: bsc_pin_out <= bsc_sh_r;
                `OP_RESET: cpu_reset_req <= rst_sh_r;
                `OP_CPU_SCAN: begin
                    inject_word <= cpu_sh_r;
                    inj_pend_r <= 1'b1;
                end
                `OP_BP_SCAN: bp_cfg_r <= bp_sh_r;
                default: inj_pend_r <= inj_pend_r;
            endcase
        end else if (run_idle && inj_pend_r && ir_eff == `OP_CPU_SCAN) begin
            // the injected word executes only once the tap rests in idle
            inject_strobe <= 1'b1;
            inj_pend_r <= 1'b0;
        end
    end
end

// tdo changes on the falling test clock so the far end samples it stable
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        test_data_out_pin <= 1'b0;
        test_data_out_oe <= 1'b0;
    end else if (!tap_on) begin
        test_data_out_oe <= 1'b0;
    end else if (fall) begin
        test_data_out_oe <= (st_r == `TS_SH_IR) | (st_r == `TS_SH_DR);
        if (st_r == `TS_SH_IR)
            test_data_out_pin <= ir_sh_r[0];
        else if (st_r == `TS_SH_DR)
            test_data_out_pin <= dr_bit;
    end
end

// ----------------------------------------------------------------
// cpu side comm register
// ----------------------------------------------------------------
wire cpu_comm_wr = bus_wr & (bus_addr == `OFF_COMM);
wire dbg_comm_rd = upd_dr & (ir_eff == `OP_COMM);

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        comm_r <= `COMM_RST;
        dirty_r <= 1'b0;
        bus_rdata <= 8'h00;
    end else begin
        if (cpu_comm_wr)
            comm_r <= bus_wdata;
        // a cpu write landing with the debugger's read keeps the flag set
        if (cpu_comm_wr)
            dirty_r <= 1'b1;
        else if (dbg_comm_rd)
            dirty_r <= 1'b0;
        bus_rdata <= 8'h00;
        if (bus_rd) begin
            case (bus_addr)
                `OFF_COMM: bus_rdata <= {dirty_r, comm_r[6:0]};
                `OFF_STAT: bus_rdata <= {5'h00, break_req, debug_active, tap_on};
                default: bus_rdata <= 8'h00;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// break point unit
// ----------------------------------------------------------------
wire [2:0] bp_mode = bp_cfg_r[`BP_MODE_LSB+2:`BP_MODE_LSB];
wire [3:0] bp_en = bp_cfg_r[`BP_EN_LSB+3:`BP_EN_LSB];
wire [15:0] bp0 = bp_cfg_r[`BP_ADDR_LSB+15:`BP_ADDR_LSB];
wire [15:0] bp1 = bp_cfg_r[`BP_ADDR_LSB+31:`BP_ADDR_LSB+16];
wire [15:0] bp2 = bp_cfg_r[`BP_ADDR_LSB+47:`BP_ADDR_LSB+32];
wire [15:0] bp3 = bp_cfg_r[`BP_ADDR_LSB+63:`BP_ADDR_LSB+48];

wire p0 = bp_en[0] & (cpu_pc == bp0);
wire p1 = bp_en[1] & (cpu_pc == bp1);
wire p2 = bp_en[2] & (cpu_pc == bp2);
wire p3 = bp_en[3] & (cpu_pc == bp3);
wire d2 = bp_en[2] & (cpu_data_addr == bp2);
wire d3 = bp_en[3] & (cpu_data_addr == bp3);
// third break point holds the base, fourth the mask of ignored bits
wire pr = bp_en[2] & ((cpu_pc & ~bp3) == (bp2 & ~bp3));
wire dr = bp_en[2] & ((cpu_data_addr & ~bp3) == (bp2 & ~bp3));

reg p_hit, d_hit;
always @* begin
    case (bp_mode)
        `BPM_4P: begin
            p_hit = p0 | p1 | p2 | p3;
            d_hit = 1'b0;
        end
        `BPM_3P1D: begin
            p_hit = p0 | p1 | p2;
            d_hit = d3;
        end
        `BPM_2P2D: begin
            p_hit = p0 | p1;
            d_hit = d2 | d3;
        end
        `BPM_PRANGE: begin
            p_hit = p0 | p1 | pr;
            d_hit = 1'b0;
        end
        `BPM_DRANGE: begin
            p_hit = p0 | p1;
            d_hit = dr;
        end
        default: begin
            p_hit = p0 | p1;
            d_hit = 1'b0;
        end
    endcase
end

wire flow_hit = bp_cfg_r[`BP_FLOW_BIT] & cpu_flow_change;
wire step_hit = bp_cfg_r[`BP_STEP_BIT];

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
        break_req <= 1'b0;
    else
        break_req <= debug_active & ((cpu_pc_valid & (p_hit | flow_hit | step_hit)) |
                                     (cpu_data_valid & d_hit));
end

endmodule

// *** logic/tap_debug_defines.vh ***
// constants for the test access port and debug block
`ifndef TAP_DEBUG_DEFINES_VH
`define TAP_DEBUG_DEFINES_VH

// tap controller state codes
`define TS_TLR 4'hF
`define TS_RTI 4'hC
`define TS_SEL_DR 4'h7
`define TS_CAP_DR 4'h6
`define TS_SH_DR 4'h2
`define TS_EX1_DR 4'h1
`define TS_PAU_DR 4'h3
`define TS_EX2_DR 4'h0
`define TS_UPD_DR 4'h5
`define TS_SEL_IR 4'h4
`define TS_CAP_IR 4'hE
`define TS_SH_IR 4'hA
`define TS_EX1_IR 4'h9
`define TS_PAU_IR 4'hB
`define TS_EX2_IR 4'h8
`define TS_UPD_IR 4'hD

// instruction codes
`define IR_W 4
`define IR_CAPTURE 4'h1
`define OP_EXTEST 4'h0
`define OP_IDCODE 4'h1
`define OP_SAMPLE 4'h2
`define OP_CPU_SCAN 4'h8
`define OP_BP_SCAN 4'h9
`define OP_COMM 4'hA
`define OP_RESET 4'hC
`define OP_BYPASS 4'hF

// chain widths and break point chain fields
`define ID_W 32
`define CPU_SCAN_W 16
`define COMM_W 8
`define BP_W 73
`define BP_MODE_LSB 0
`define BP_FLOW_BIT 3
`define BP_STEP_BIT 4
`define BP_EN_LSB 5
`define BP_ADDR_LSB 9

// break point layouts
`define BPM_4P 3'h0
`define BPM_3P1D 3'h1
`define BPM_2P2D 3'h2
`define BPM_PRANGE 3'h3
`define BPM_DRANGE 3'h4

// cpu side register offsets and reset values
`define OFF_COMM 2'h0
`define OFF_STAT 2'h1
`define COMM_RST 8'h00

`endif

// *** test/tap_debug_properties.sv ***
// concurrent checks on the ports of the test access port block
`timescale 1ns/10ps
module tap_debug_properties (
    input wire mclk,
    input wire arst_n,
    input wire test_clock_pin,
    input wire test_data_out_oe,
    input wire tap_pullup_en,
    input wire tap_port_enable_fuse,
    input wire debug_enable_fuse,
    input wire lock_bit_one,
    input wire lock_bit_two,
    input wire inject_strobe,
    input wire break_req,
    input wire debug_active,
    input wire [1:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_comm_wr;
        bus_wr && bus_addr == 2'h0;
    endsequence
    sequence s_comm_rd;
        bus_rd && bus_addr == 2'h0;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_fuse_off_quiet: assert property (
        !tap_port_enable_fuse [*4] |=> !test_data_out_oe && !tap_pullup_en)
        else $error("port active with enable fuse off");
    chk_pullup_on: assert property (tap_port_enable_fuse [*4] |=> tap_pullup_en)
        else $error("pullup missing with enable fuse on");
    chk_debug_gate: assert property (
        debug_active |-> $past(debug_enable_fuse && !lock_bit_one && !lock_bit_two, 3))
        else $error("debug active without fuse or with lock bit");
    chk_break_gate: assert property (break_req |-> $past(debug_active))
        else $error("break raised while debug inactive");
    chk_inject_gate: assert property (
        inject_strobe |-> debug_active ##1 !inject_strobe)
        else $error("inject strobe ungated or too long");
    chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_dirty_set: assert property (s_comm_wr ##2 s_comm_rd |=> bus_rdata[7])
        else $error("dirty flag not set after cpu write");
    chk_oe_on_fall: assert property ($changed(test_data_out_oe) |-> !test_clock_pin)
        else $error("tdo enable moved while test clock high");
endmodule

// *** test/jtag_probe.sv ***
// behavioural external test controller on the four test pins
`timescale 1ns/10ps
module jtag_probe (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic rst_pull_n,
    input wire tdo,
    input wire sys_rst_n
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        rst_pull_n = 1'b1;
    end
    // one 125 ns test clock period; tdo read just before the rise
    task automatic step(input logic t, input logic d, output logic q);
        tms = t;
        tdi = d;
        #62.5 q = tdo;
        tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask
    // open-collector pull of the shared system reset, watching that the line went low
    task automatic pull_reset(output logic seen);
        rst_pull_n = 1'b0;
        #250 seen = !sys_rst_n;
        rst_pull_n = 1'b1;
        #250;
    endtask
    // idle to shift, n bits, back to idle
    task automatic scan(input logic ir, input int n, input logic [79:0] din,
        output logic [79:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    task automatic reset5();
        logic q;
        for (int i = 0; i < 5; i++)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule

// *** test/tb_tap_debug_access_port.sv ***
// self-checking bench for the test access port and debug block
`timescale 1ns/10ps
module tb_tap_debug_access_port;
    // arbitrary identification value, low bit set
    localparam logic [31:0] ID_VAL = 32'h0C3C_3001;
    // expected break per layout pass, one nibble each: pc hit, bp2 fetch, bp2 data, flow
    localparam logic [23:0] BP_EXP = 24'h35BBD3;
    logic mclk, arst_n, tck, tms, tdi, tdo, oe, pull, bsc_drive, rst_req, inj, brk, dbg;
    logic fuse_tap, debug_enable_fuse, lock_bit_one, lock_bit_two;
    logic cpu_pc_valid, cpu_flow_change, cpu_data_valid, bus_wr, bus_rd;
    logic [7:0] bsc_pin_in, bsc_pin_out, bus_wdata, bus_rdata;
    logic [15:0] inject_word, cpu_pc, cpu_data_addr;
    logic [1:0] bus_addr;
    logic seen, rst_pull_n;
    // the probe shares the reset line as an open-collector driver
    wire sys_rst_n = arst_n & rst_pull_n;
    logic [79:0] v, ch;
    logic [31:0] seed, r;
    logic q;
    int error_cnt, compares, cycles, strobes;
    tap_debug_access_port #(.BSC_LEN(8), .ID_CODE(ID_VAL)) u_dut (
        .mclk(mclk), .arst_n(sys_rst_n), .test_clock_pin(tck), .test_mode_select_pin(tms),
        .test_data_in_pin(tdi), .test_data_out_pin(tdo), .test_data_out_oe(oe),
        .tap_pullup_en(pull), .tap_port_enable_fuse(fuse_tap),
        .debug_enable_fuse(debug_enable_fuse), .lock_bit_one(lock_bit_one),
        .lock_bit_two(lock_bit_two), .bsc_pin_in(bsc_pin_in), .bsc_pin_out(bsc_pin_out),
        .bsc_drive(bsc_drive), .cpu_reset_req(rst_req), .inject_word(inject_word),
        .inject_strobe(inj), .cpu_pc(cpu_pc), .cpu_pc_valid(cpu_pc_valid),
        .cpu_flow_change(cpu_flow_change), .cpu_data_addr(cpu_data_addr),
        .cpu_data_valid(cpu_data_valid), .break_req(brk), .debug_active(dbg),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata)
    );
    jtag_probe u_probe (
        .tck(tck), .tms(tms), .tdi(tdi), .rst_pull_n(rst_pull_n), .tdo(tdo),
        .sys_rst_n(sys_rst_n)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic check(input string name, input logic [79:0] exp, input logic [79:0] seen);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bwr(input logic [1:0] a, input logic [7:0] x);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= x;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask
    task automatic brd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 check("rdata", exp, bus_rdata);
    endtask
    task automatic hit(input logic [15:0] a, input logic [2:0] k, input logic exp);
        @(posedge mclk);
        cpu_pc <= a;
        cpu_data_addr <= a;
        {cpu_pc_valid, cpu_flow_change, cpu_data_valid} <= k;
        @(posedge mclk);
        {cpu_pc_valid, cpu_flow_change, cpu_data_valid} <= 3'b000;
        #1 check("break", exp, brk);
    endtask
    task automatic pins(input logic [3:0] k);
        @(posedge mclk);
        {fuse_tap, debug_enable_fuse, lock_bit_one, lock_bit_two} <= k;
        repeat (6) @(posedge mclk);
        #3;
    endtask
    // ------------------------------------------------------------
    // clock, timeout, strobe count
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (inj === 1'b1)
            strobes <= strobes + 1;
        if (cycles == 60000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hE505;
        {arst_n, cycles, strobes, error_cnt, compares} = '0;
        {fuse_tap, debug_enable_fuse, lock_bit_one, lock_bit_two} = 4'b1100;
        {bsc_pin_in, cpu_pc, cpu_data_addr, bus_addr, bus_wdata} = '0;
        {cpu_pc_valid, cpu_flow_change, cpu_data_valid, bus_wr, bus_rd} = '0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        pins(4'b1100);
        u_probe.step(1'b0, 1'b1, q);
        u_probe.scan(0, 32, '1, v);
        check("idcode", ID_VAL, v);
        r = rnd();
        u_probe.scan(1, 4, 4'hF, v);
        check("ir_capture", 4'h1, v);
        u_probe.scan(0, 8, r[7:0], v);
        check("bypass", {r[6:0], 1'b0}, v);
        @(posedge mclk);
        bsc_pin_in <= r[15:8];
        u_probe.scan(1, 4, 4'h2, v);
        u_probe.scan(0, 8, r[31:24], v);
        check("sample", r[15:8], v);
        check("preload", {r[31:24], bsc_drive}, {bsc_pin_out, 1'b0});
        u_probe.scan(1, 4, 4'h0, v);
        check("extest", 1'b1, bsc_drive);
        for (int i = 1; i >= 0; i--) begin
            u_probe.scan(1, 4, 4'hC, v);
            u_probe.scan(0, 1, i, v);
            check("cpu_reset", i, rst_req);
        end
        bwr(2'h0, r[7:0]);
        brd(2'h0, {1'b1, r[6:0]});
        bwr(2'h1, 8'hFF);
        brd(2'h1, 8'h03);
        bwr(2'h3, 8'hFF);
        brd(2'h3, 8'h00);
        u_probe.scan(1, 4, 4'hA, v);
        u_probe.scan(0, 8, 8'h00, v);
        check("comm", r[7:0], v);
        brd(2'h0, {1'b0, r[6:0]});
        u_probe.scan(1, 4, 4'h8, v);
        u_probe.scan(0, 16, r[31:16], v);
        check("inject_word", r[31:16], inject_word);
        u_probe.step(1'b0, 1'b1, q);
        repeat (4) @(posedge mclk);
        check("inject_once", 1, strobes);
        for (int i = 0; i < 6; i++) begin
            ch = '0;
            ch[2:0] = (i == 2) ? 3'h0 : (i == 5) ? 3'h1 : (i == 1) ? 3'h2 : i[2:0];
            ch[3] = (i == 1);
            ch[4] = (i == 2);
            ch[8:5] = 4'b0101;
            ch[24:9] = r[15:0];
            ch[56:41] = r[15:0] ^ 16'h00F0;
            ch[72:57] = 16'h00FF;
            u_probe.scan(1, 4, 4'h9, v);
            u_probe.scan(0, 73, ch, v);
            hit(r[15:0], 3'b100, BP_EXP[4*i]);
            hit(ch[56:41], 3'b100, BP_EXP[4*i+1]);
            hit(ch[56:41], 3'b001, BP_EXP[4*i+2]);
            hit(r[15:0] ^ 16'h0001, 3'b110, BP_EXP[4*i+3]);
        end
        for (int i = 0; i < 8; i++) begin
            pins({1'b1, i[2:0]});
            brd(2'h1, {6'h00, i == 4, 1'b1});
            check("debug_active", i == 4, dbg);
        end
        u_probe.scan(1, 4, 4'h8, v);
        u_probe.scan(0, 2, 2'b11, v);
        u_probe.step(1'b0, 1'b1, q);
        check("locked_scan", {2'b10, 32'h1}, {v[1:0], strobes});
        u_probe.scan(1, 4, 4'hF, v);
        u_probe.step(1'b1, 1'b1, q);
        u_probe.step(1'b0, 1'b1, q);
        u_probe.reset5();
        u_probe.scan(0, 32, '1, v);
        check("tms_reset", ID_VAL, v);
        u_probe.scan(1, 4, 4'hF, v);
        pins(4'b0100);
        check("fuse_off", 2'b00, {pull, oe});
        pins(4'b1100);
        u_probe.step(1'b0, 1'b1, q);
        u_probe.scan(0, 32, '1, v);
        check("fuse_reset", {1'b1, ID_VAL}, {pull, v[31:0]});
        u_probe.scan(1, 4, 4'hF, v);
        u_probe.pull_reset(seen);
        u_probe.step(1'b0, 1'b1, q);
        u_probe.scan(0, 32, '1, v);
        check("probe_reset", {1'b1, ID_VAL}, {seen, v[31:0]});
        stop_test();
    end
endmodule
bind tap_debug_access_port tap_debug_properties u_props (
    .mclk(mclk), .arst_n(arst_n), .test_clock_pin(test_clock_pin),
    .test_data_out_oe(test_data_out_oe), .tap_pullup_en(tap_pullup_en),
    .tap_port_enable_fuse(tap_port_enable_fuse), .debug_enable_fuse(debug_enable_fuse),
    .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two), .inject_strobe(inject_strobe),
    .break_req(break_req), .debug_active(debug_active), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata)
);
